/* ppo_ovr_gen.sv */
// override signal generation for both ports
`timescale 1ns/1ps
module ppo_ovr_gen (
  // port registers
  input wire ppo_pkg::ppo_pins_t pin_out_bit,
  input wire logic global_pullup_off,
  // memory interface
  input wire logic ext_mem_enable,
  input wire logic addr_phase_active,
  input wire logic wr_strobe,
  input wire ppo_pkg::ppo_byte_t mem_addr_lo,
  input wire ppo_pkg::ppo_byte_t mem_dout,
  // serial interface and counter
  input wire logic spi_en,
  input wire logic spi_master,
  input wire logic spi_sck_out,
  input wire logic spi_master_out,
  input wire logic spi_slave_out,
  input wire logic cnt8_match_en,
  input wire logic cnt8_match_out,
  // overrides
  ppo_ovr_if.gen ovr
);
  import ppo_pkg::*;

  logic bus_busy;
  logic slv;
  logic mst;

  assign bus_busy = wr_strobe | addr_phase_active; // R5
  assign slv = spi_en & ~spi_master;
  assign mst = spi_en & spi_master;

  always_comb begin
    ovr.pullup_override_enable = '0;
    ovr.pullup_override_value = '0;
    ovr.dir_override_enable = '0;
    ovr.dir_override_value = '0;
    ovr.value_override_enable = '0;
    ovr.value_override_value = '0;
    // ********************************************************
    // first port: address and data lines
    // ********************************************************
    for (int i = 0; i < PORT_W; i++) begin
      ovr.pullup_override_enable[i] = ext_mem_enable; // R3 R4
      ovr.pullup_override_value[i] = ~bus_busy & pin_out_bit[i]; // R4
      ovr.dir_override_enable[i] = ext_mem_enable; // R3
      ovr.dir_override_value[i] = bus_busy; // R3
      ovr.value_override_enable[i] = ext_mem_enable; // R3
      ovr.value_override_value[i] = (mem_addr_lo[i] & addr_phase_active) | (mem_dout[i] & wr_strobe); // R2 R3
    end
    // ********************************************************
    // second port: serial interface pins
    // ********************************************************
    ovr.pullup_override_enable[PB_BASE+SCK_BIT] = slv; // R6
    ovr.dir_override_enable[PB_BASE+SCK_BIT] = slv; // R6
    ovr.value_override_enable[PB_BASE+SCK_BIT] = mst;
    ovr.value_override_value[PB_BASE+SCK_BIT] = spi_sck_out;
    ovr.pullup_override_enable[PB_BASE+MST_IN_BIT] = mst; // R7
    ovr.dir_override_enable[PB_BASE+MST_IN_BIT] = mst; // R7
    ovr.value_override_enable[PB_BASE+MST_IN_BIT] = slv;
    ovr.value_override_value[PB_BASE+MST_IN_BIT] = spi_slave_out;
    ovr.pullup_override_enable[PB_BASE+MST_OUT_BIT] = slv; // R8
    ovr.dir_override_enable[PB_BASE+MST_OUT_BIT] = slv; // R8
    ovr.value_override_enable[PB_BASE+MST_OUT_BIT] = mst;
    ovr.value_override_value[PB_BASE+MST_OUT_BIT] = spi_master_out;
    ovr.pullup_override_enable[PB_BASE+SEL_BIT] = slv; // R9
    ovr.dir_override_enable[PB_BASE+SEL_BIT] = slv; // R9
    for (int b = SEL_BIT; b <= SCK_BIT; b++) begin
      ovr.pullup_override_value[PB_BASE+b] = pin_out_bit[PB_BASE+b] & ~global_pullup_off; // R10
    end
    // ********************************************************
    // second port: compare output
    // ********************************************************
    ovr.value_override_enable[PB_BASE+CNT8_BIT] = cnt8_match_en; // R12
    ovr.value_override_value[PB_BASE+CNT8_BIT] = cnt8_match_out; // R12
  end

endmodule

/* ppo_ovr_if.sv */
// override signal bundle between generator and pin resolver
`timescale 1ns/1ps
interface ppo_ovr_if;
  import ppo_pkg::*;
  ppo_pins_t pullup_override_enable;
  ppo_pins_t pullup_override_value;
  ppo_pins_t dir_override_enable;
  ppo_pins_t dir_override_value;
  ppo_pins_t value_override_enable;
  ppo_pins_t value_override_value;

  modport gen (
    output pullup_override_enable,
    output pullup_override_value,
    output dir_override_enable,
    output dir_override_value,
    output value_override_enable,
    output value_override_value
  );

  modport sink (
    input pullup_override_enable,
    input pullup_override_value,
    input dir_override_enable,
    input dir_override_value,
    input value_override_enable,
    input value_override_value
  );
endinterface

/* ppo_pad_model.sv */
// pad and far-side driver model for one 8-bit port
`timescale 1ns/1ps
module ppo_pad_model (
  // clock for the floating-pin pattern
  input wire logic clk,
  // pad controls from the block
  input wire ppo_pkg::ppo_byte_t pad_out,
  input wire ppo_pkg::ppo_byte_t pad_oe,
  input wire ppo_pkg::ppo_byte_t pu_en,
  // far-side driver
  input wire ppo_pkg::ppo_byte_t ext_en,
  input wire ppo_pkg::ppo_byte_t ext_val,
  // pad level seen by the block
  output ppo_pkg::ppo_byte_t pad_in
);
  import ppo_pkg::*;
  // a floating pin changes every cycle so no stale value passes for a real one
  ppo_byte_t float_ff = 8'h55;
  always_ff @(posedge clk) begin
    float_ff <= ~float_ff;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else
        pad_in[i] = pu_en[i] | float_ff[i];
    end
  end
endmodule

/* ppo_pin_cell.sv */
// per-pin resolution of override and register controls
`timescale 1ns/1ps
module ppo_pin_cell (
  // port registers
  input wire ppo_pkg::ppo_pins_t pin_dir_bit,
  input wire ppo_pkg::ppo_pins_t pin_out_bit,
  input wire logic global_pullup_off,
  // overrides
  ppo_ovr_if.sink ovr,
  // pad controls
  output ppo_pkg::ppo_pins_t nxt_pad_out,
  output ppo_pkg::ppo_pins_t nxt_pad_oe,
  output ppo_pkg::ppo_pins_t nxt_pullup
);
  import ppo_pkg::*;

  genvar g;
  generate
    for (g = 0; g < PIN_N; g++) begin : g_pin
      assign nxt_pullup[g] = ovr.pullup_override_enable[g] ? ovr.pullup_override_value[g]
                           : ({pin_dir_bit[g], pin_out_bit[g], global_pullup_off} == 3'h2); // R13 R1
      assign nxt_pad_oe[g] = ovr.dir_override_enable[g] ? ovr.dir_override_value[g] : pin_dir_bit[g]; // R14
      assign nxt_pad_out[g] = ovr.value_override_enable[g] ? ovr.value_override_value[g]
                            : pin_out_bit[g]; // R15 R16
    end
  endgenerate

endmodule

/* ppo_pkg.sv */
// constants and types shared by the port override block
package ppo_pkg;

  // ********************************************************
  // widths
  // ********************************************************
  localparam int PORT_W = 8;
  localparam int PIN_N = 16;
  localparam int PB_BASE = 8;

  // ********************************************************
  // second port alternate-function bit positions
  // ********************************************************
  localparam int SCK_BIT = 7;
  localparam int MST_IN_BIT = 6;
  localparam int MST_OUT_BIT = 5;
  localparam int SEL_BIT = 4;
  localparam int CMP_NEG_BIT = 3;
  localparam int CMP_POS_BIT = 2;
  localparam int CNT16_BIT = 1;
  localparam int CNT8_BIT = 0;

  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [PORT_W-1:0] PORT_RST = 8'h00;
  localparam logic [PIN_N-1:0] PINS_RST = 16'h0000;
  localparam logic BIT_RST = 1'h0;
  localparam logic [1:0] RST_SYNC_RST = 2'h0;

  typedef logic [PORT_W-1:0] ppo_byte_t;
  typedef logic [PIN_N-1:0] ppo_pins_t;

endpackage

/* ppo_port_override.sv */
// top of the two-port alternate function override block
// Function
// R1 - a set global pull-up disable turns off every register-controlled pull-up, even with direction 0 and output 1.
// R2 - first port pin n carries memory address and data bit n.
// R3 - with external memory on, upper first-port pins drive during address phase or write, address then data.
// R4 - lower first-port pins use the same scheme, pull-up only when idle and output bit set, input feeds data in.
// R5 - the address-active term is high exactly while the memory interface puts the address on the pins.
// R6 - serial clock pin is forced to input in slave mode and follows its direction bit in master mode.
// R7 - master-input pin is forced to input in master mode and follows its direction bit in slave mode.
// R8 - master-output pin is forced to input in slave mode and follows its direction bit in master mode.
// R9 - select pin is input in slave mode and the serial slave is active only while it is low.
// R10 - a pin forced to input by the serial interface keeps its pull-up under its output bit.
// R11 - software sets both comparator pins as inputs with pull-ups off.
// R12 - second-port bit 1 feeds the 16-bit counter, bit 0 feeds the 8-bit counter and can drive its match output.
// R13 - a pull-up override selects the override value, else pull-up is on for direction, output, disable of 0b010.
// R14 - a direction override selects the override value for the driver, else the direction bit does.
// R15 - a value override on a driven pin drives the override value instead of the output bit.
// R16 - owners supply overrides combinationally and the register path applies when no override is set.
`timescale 1ns/1ps
module ppo_port_override (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  // port registers
  input wire logic GLOBAL_PULLUP_OFF,
  input wire ppo_pkg::ppo_byte_t PA_DIR_BIT,
  input wire ppo_pkg::ppo_byte_t PA_OUT_BIT,
  input wire ppo_pkg::ppo_byte_t PB_DIR_BIT,
  input wire ppo_pkg::ppo_byte_t PB_OUT_BIT,
  // external memory interface
  input wire logic EXT_MEM_ENABLE,
  input wire logic ADDR_PHASE_ACTIVE,
  input wire logic WR_STROBE,
  input wire ppo_pkg::ppo_byte_t MEM_ADDR_LO,
  input wire ppo_pkg::ppo_byte_t MEM_DOUT,
  output ppo_pkg::ppo_byte_t MEM_DIN,
  // serial interface
  input wire logic SPI_EN,
  input wire logic SPI_MASTER,
  input wire logic SPI_SCK_OUT,
  input wire logic SPI_MASTER_OUT,
  input wire logic SPI_SLAVE_OUT,
  output logic SPI_SCK_IN,
  output logic SPI_MASTER_IN,
  output logic SPI_SLAVE_IN,
  output logic SPI_SELECT_N,
  output logic SPI_SLAVE_ACTIVE,
  // counters
  input wire logic CNT8_MATCH_EN,
  input wire logic CNT8_MATCH_OUT,
  output logic CNT8_EXT_COUNT_IN,
  output logic CNT16_EXT_COUNT_IN,
  // pin state readback
  output ppo_pkg::ppo_byte_t PA_PIN_STATE,
  output ppo_pkg::ppo_byte_t PB_PIN_STATE,
  // first port pads
  input wire ppo_pkg::ppo_byte_t PA_PAD_IN,
  output ppo_pkg::ppo_byte_t PA_PAD_OUT,
  output ppo_pkg::ppo_byte_t PA_PAD_OE,
  output ppo_pkg::ppo_byte_t PA_PULLUP,
  // second port pads
  input wire ppo_pkg::ppo_byte_t PB_PAD_IN,
  output ppo_pkg::ppo_byte_t PB_PAD_OUT,
  output ppo_pkg::ppo_byte_t PB_PAD_OE,
  output ppo_pkg::ppo_byte_t PB_PULLUP
);
  import ppo_pkg::*;

  // ********************************************************
  // reset release
  // ********************************************************
  logic [1:0] rst_sync_ff;
  logic rst_n;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_sync_ff <= RST_SYNC_RST;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'h1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ********************************************************
  // override generation and pin resolution
  // ********************************************************
  ppo_ovr_if ovr_bus ();

  ppo_pins_t dir_bits;
  ppo_pins_t out_bits;
  ppo_pins_t pad_in;
  ppo_pins_t nxt_pad_out;
  ppo_pins_t nxt_pad_oe;
  ppo_pins_t nxt_pullup;

  assign dir_bits = {PB_DIR_BIT, PA_DIR_BIT};
  assign out_bits = {PB_OUT_BIT, PA_OUT_BIT};
  assign pad_in = {PB_PAD_IN, PA_PAD_IN};

  ppo_ovr_gen u_gen (
    .pin_out_bit(out_bits),
    .global_pullup_off(GLOBAL_PULLUP_OFF),
    .ext_mem_enable(EXT_MEM_ENABLE),
    .addr_phase_active(ADDR_PHASE_ACTIVE),
    .wr_strobe(WR_STROBE),
    .mem_addr_lo(MEM_ADDR_LO),
    .mem_dout(MEM_DOUT),
    .spi_en(SPI_EN),
    .spi_master(SPI_MASTER),
    .spi_sck_out(SPI_SCK_OUT),
    .spi_master_out(SPI_MASTER_OUT),
    .spi_slave_out(SPI_SLAVE_OUT),
    .cnt8_match_en(CNT8_MATCH_EN),
    .cnt8_match_out(CNT8_MATCH_OUT),
    .ovr(ovr_bus.gen)
  );

  ppo_pin_cell u_cell (
    .pin_dir_bit(dir_bits),
    .pin_out_bit(out_bits),
    .global_pullup_off(GLOBAL_PULLUP_OFF),
    .ovr(ovr_bus.sink),
    .nxt_pad_out(nxt_pad_out),
    .nxt_pad_oe(nxt_pad_oe),
    .nxt_pullup(nxt_pullup)
  );

  // ********************************************************
  // pad control registers
  // ********************************************************
  ppo_pins_t pad_out_ff;
  ppo_pins_t pad_oe_ff;
  ppo_pins_t pullup_ff;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_ff <= PINS_RST;
    end else if (CE) begin
      pad_out_ff <= nxt_pad_out; // R15
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pad_oe_ff <= PINS_RST;
    end else if (CE) begin
      pad_oe_ff <= nxt_pad_oe; // R14
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pullup_ff <= PINS_RST;
    end else if (CE) begin
      pullup_ff <= nxt_pullup; // R13
    end
  end

  assign PA_PAD_OUT = pad_out_ff[PORT_W-1:0];
  assign PB_PAD_OUT = pad_out_ff[PIN_N-1:PB_BASE];
  assign PA_PAD_OE = pad_oe_ff[PORT_W-1:0];
  assign PB_PAD_OE = pad_oe_ff[PIN_N-1:PB_BASE];
  assign PA_PULLUP = pullup_ff[PORT_W-1:0];
  assign PB_PULLUP = pullup_ff[PIN_N-1:PB_BASE];

  // ********************************************************
  // pin state readback
  // ********************************************************
  ppo_pins_t pin_state_ff;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_state_ff <= PINS_RST;
    end else if (CE) begin
      pin_state_ff <= pad_in;
    end
  end

  assign PA_PIN_STATE = pin_state_ff[PORT_W-1:0];
  assign PB_PIN_STATE = pin_state_ff[PIN_N-1:PB_BASE];

  // ********************************************************
  // memory data input
  // ********************************************************
  ppo_byte_t mem_din_ff;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mem_din_ff <= PORT_RST;
    end else if (CE) begin
      mem_din_ff <= PA_PAD_IN; // R2 R4
    end
  end

  assign MEM_DIN = mem_din_ff;

  // ********************************************************
  // serial interface inputs
  // ********************************************************
  logic sck_in_ff;
  logic mst_in_ff;
  logic slv_in_ff;
  logic sel_n_ff;
  logic slv_active_ff;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sck_in_ff <= BIT_RST;
      mst_in_ff <= BIT_RST;
      slv_in_ff <= BIT_RST;
    end else if (CE) begin
      sck_in_ff <= PB_PAD_IN[SCK_BIT];
      mst_in_ff <= PB_PAD_IN[MST_IN_BIT];
      slv_in_ff <= PB_PAD_IN[MST_OUT_BIT];
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sel_n_ff <= 1'h1;
      slv_active_ff <= BIT_RST;
    end else if (CE) begin
      sel_n_ff <= PB_PAD_IN[SEL_BIT];
      slv_active_ff <= SPI_EN & ~SPI_MASTER & ~PB_PAD_IN[SEL_BIT]; // R9
    end
  end

  assign SPI_SCK_IN = sck_in_ff;
  assign SPI_MASTER_IN = mst_in_ff;
  assign SPI_SLAVE_IN = slv_in_ff;
  assign SPI_SELECT_N = sel_n_ff;
  assign SPI_SLAVE_ACTIVE = slv_active_ff;

  // ********************************************************
  // counter inputs
  // ********************************************************
  logic cnt8_in_ff;
  logic cnt16_in_ff;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt8_in_ff <= BIT_RST;
      cnt16_in_ff <= BIT_RST;
    end else if (CE) begin
      cnt8_in_ff <= PB_PAD_IN[CNT8_BIT]; // R12
      cnt16_in_ff <= PB_PAD_IN[CNT16_BIT]; // R12
    end
  end

  assign CNT8_EXT_COUNT_IN = cnt8_in_ff;
  assign CNT16_EXT_COUNT_IN = cnt16_in_ff;

endmodule

/* ppo_port_override_assertions.sv */
// concurrent checks on the port override block pins
`timescale 1ns/1ps
module ppo_port_override_assertions (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  // controls
  input wire logic GLOBAL_PULLUP_OFF,
  input wire ppo_pkg::ppo_byte_t PA_DIR_BIT,
  input wire ppo_pkg::ppo_byte_t PA_OUT_BIT,
  input wire ppo_pkg::ppo_byte_t PB_DIR_BIT,
  input wire ppo_pkg::ppo_byte_t PB_OUT_BIT,
  input wire logic EXT_MEM_ENABLE,
  input wire logic ADDR_PHASE_ACTIVE,
  input wire logic WR_STROBE,
  input wire ppo_pkg::ppo_byte_t MEM_ADDR_LO,
  input wire ppo_pkg::ppo_byte_t MEM_DOUT,
  input wire logic SPI_EN,
  input wire logic SPI_MASTER,
  input wire logic SPI_SCK_OUT,
  input wire logic SPI_MASTER_OUT,
  input wire logic CNT8_MATCH_EN,
  input wire logic CNT8_MATCH_OUT,
  // observed
  input wire ppo_pkg::ppo_byte_t MEM_DIN,
  input wire logic SPI_SLAVE_ACTIVE,
  input wire logic CNT8_EXT_COUNT_IN,
  input wire logic CNT16_EXT_COUNT_IN,
  input wire ppo_pkg::ppo_byte_t PA_PAD_IN,
  input wire ppo_pkg::ppo_byte_t PA_PAD_OUT,
  input wire ppo_pkg::ppo_byte_t PA_PAD_OE,
  input wire ppo_pkg::ppo_byte_t PA_PULLUP,
  input wire ppo_pkg::ppo_byte_t PB_PAD_IN,
  input wire ppo_pkg::ppo_byte_t PB_PAD_OUT,
  input wire ppo_pkg::ppo_byte_t PB_PAD_OE,
  input wire ppo_pkg::ppo_byte_t PB_PULLUP
);
  import ppo_pkg::*;
  // ****
  // edges since reset release; outputs follow inputs from the third on
  // ****
  logic [1:0] up_ff;
  logic live;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      up_ff <= 2'h0;
    end else if (up_ff != 2'h3) begin
      up_ff <= up_ff + 2'h1;
    end
  end
  assign live = (up_ff == 2'h3);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence taken_s(c);
    live && $past(CE && c);
  endsequence
  sequence mem_cycle_s;
    live && CE && EXT_MEM_ENABLE && ADDR_PHASE_ACTIVE && !WR_STROBE
      ##1 CE && EXT_MEM_ENABLE && WR_STROBE && !ADDR_PHASE_ACTIVE;
  endsequence
  // ****
  // checks
  // ****
  pullup_off_a: assert property (taken_s(GLOBAL_PULLUP_OFF && !EXT_MEM_ENABLE) |->
    PA_PULLUP == 8'h00 && PB_PULLUP == 8'h00) else $error("pull-up on while disabled");
  addr_out_a: assert property (taken_s(EXT_MEM_ENABLE && ADDR_PHASE_ACTIVE && !WR_STROBE) |->
    PA_PAD_OE == 8'hFF && PA_PAD_OUT == $past(MEM_ADDR_LO) && PA_PULLUP == 8'h00) else $error("address not driven");
  write_data_a: assert property (mem_cycle_s |=> PA_PAD_OE == 8'hFF && PA_PAD_OUT == $past(MEM_DOUT))
    else $error("write data not driven");
  mem_idle_a: assert property (taken_s(EXT_MEM_ENABLE && !ADDR_PHASE_ACTIVE && !WR_STROBE) |->
    PA_PAD_OE == 8'h00 && PA_PULLUP == $past(PA_OUT_BIT)) else $error("idle bus wrong");
  pad_input_a: assert property (taken_s(1'b1) |-> MEM_DIN == $past(PA_PAD_IN) &&
    CNT8_EXT_COUNT_IN == $past(PB_PAD_IN[0]) && CNT16_EXT_COUNT_IN == $past(PB_PAD_IN[1]) &&
    SPI_SLAVE_ACTIVE == $past(SPI_EN && !SPI_MASTER && !PB_PAD_IN[4])) else $error("pad input path wrong");
  slave_pins_a: assert property (taken_s(SPI_EN && !SPI_MASTER) |-> (PB_PAD_OE & 8'hB0) == 8'h00 &&
    (PB_PULLUP & 8'hB0) == ($past(PB_OUT_BIT & {8{!GLOBAL_PULLUP_OFF}}) & 8'hB0)) else $error("slave pins wrong");
  master_pins_a: assert property (taken_s(SPI_EN && SPI_MASTER) |-> !PB_PAD_OE[6] &&
    PB_PULLUP[6] == $past(PB_OUT_BIT[6] && !GLOBAL_PULLUP_OFF) && PB_PAD_OE[7] == $past(PB_DIR_BIT[7]) &&
    PB_PAD_OUT[7] == $past(SPI_SCK_OUT) && PB_PAD_OUT[5] == $past(SPI_MASTER_OUT)) else $error("master pins wrong");
  match_out_a: assert property (taken_s(CNT8_MATCH_EN) |-> PB_PAD_OUT[0] == $past(CNT8_MATCH_OUT) &&
    PB_PAD_OE[0] == $past(PB_DIR_BIT[0])) else $error("match output wrong");
  plain_port_a: assert property (taken_s(!EXT_MEM_ENABLE) |-> PA_PAD_OE == $past(PA_DIR_BIT) &&
    PA_PAD_OUT == $past(PA_OUT_BIT) && PA_PULLUP == $past(~PA_DIR_BIT & PA_OUT_BIT & {8{!GLOBAL_PULLUP_OFF}}))
    else $error("register path wrong");
endmodule

bind ppo_port_override ppo_port_override_assertions ppo_port_override_assertions_inst (.*);

/* tb.sv */
// testbench for the port override block
`timescale 1ns/1ps
`define CK(n, s, e) begin tests_run++; if ((s) !== (e)) begin err_total++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb;
  import ppo_pkg::*;
  logic CLK, RSTN, CE, GLOBAL_PULLUP_OFF, EXT_MEM_ENABLE, ADDR_PHASE_ACTIVE, WR_STROBE, SPI_EN, SPI_MASTER;
  logic SPI_SCK_OUT, SPI_MASTER_OUT, SPI_SLAVE_OUT, CNT8_MATCH_EN, CNT8_MATCH_OUT;
  logic SPI_SCK_IN, SPI_MASTER_IN, SPI_SLAVE_IN, SPI_SELECT_N, SPI_SLAVE_ACTIVE, CNT8_EXT_COUNT_IN, CNT16_EXT_COUNT_IN;
  ppo_byte_t PA_DIR_BIT, PA_OUT_BIT, PB_DIR_BIT, PB_OUT_BIT, MEM_ADDR_LO, MEM_DOUT, MEM_DIN, PA_PIN_STATE;
  ppo_byte_t PA_PAD_IN, PA_PAD_OUT, PA_PAD_OE, PA_PULLUP, PB_PAD_IN, PB_PAD_OUT, PB_PAD_OE, PB_PULLUP, PB_PIN_STATE;
  ppo_byte_t pa_xe, pa_xv, pb_xe, pb_xv;
  int err_total, tests_run, cyc;
  ppo_port_override ppo_port_override_inst (.*);
  ppo_pad_model ppo_pad_model_inst (.clk(CLK), .pad_out(PA_PAD_OUT), .pad_oe(PA_PAD_OE), .pu_en(PA_PULLUP),
    .ext_en(pa_xe), .ext_val(pa_xv), .pad_in(PA_PAD_IN));
  ppo_pad_model ppo_pad_model_pb_inst (.clk(CLK), .pad_out(PB_PAD_OUT), .pad_oe(PB_PAD_OE), .pu_en(PB_PULLUP),
    .ext_en(pb_xe), .ext_val(pb_xv), .pad_in(PB_PAD_IN));
  always #12.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      stop_test();
    end
  end
  task tick();
    @(posedge CLK);
    #2;
  endtask
  task stop_test();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // expected pad controls worked out from the inputs now applied, compared after one edge
  task chk();
    ppo_byte_t eo, ee, ep, fo, fe, fp, g;
    g = {8{!GLOBAL_PULLUP_OFF}};
    if (EXT_MEM_ENABLE) begin
      ee = {8{WR_STROBE | ADDR_PHASE_ACTIVE}};
      eo = (MEM_ADDR_LO & {8{ADDR_PHASE_ACTIVE}}) | (MEM_DOUT & {8{WR_STROBE}});
      ep = ~ee & PA_OUT_BIT;
    end else begin
      ee = PA_DIR_BIT;
      eo = PA_OUT_BIT;
      ep = ~PA_DIR_BIT & PA_OUT_BIT & g;
    end
    fe = PB_DIR_BIT;
    fo = PB_OUT_BIT;
    fp = ~PB_DIR_BIT & PB_OUT_BIT & g;
    if (CNT8_MATCH_EN)
      fo[0] = CNT8_MATCH_OUT;
    if (SPI_EN && !SPI_MASTER) begin
      fe &= 8'h4F;
      fp = (fp & 8'h4F) | (PB_OUT_BIT & g & 8'hB0);
      fo[6] = SPI_SLAVE_OUT;
    end else if (SPI_EN) begin
      fe[6] = 1'b0;
      fp[6] = PB_OUT_BIT[6] & g[6];
      fo[7] = SPI_SCK_OUT;
      fo[5] = SPI_MASTER_OUT;
    end
    tick();
    `CK("pa_out", PA_PAD_OUT, eo)
    `CK("pa_oe", PA_PAD_OE, ee)
    `CK("pa_pullup", PA_PULLUP, ep)
    `CK("pb_out", PB_PAD_OUT, fo)
    `CK("pb_oe", PB_PAD_OE, fe)
    `CK("pb_pullup", PB_PULLUP, fp)
  endtask
  initial begin
    {CLK, RSTN, GLOBAL_PULLUP_OFF, EXT_MEM_ENABLE, ADDR_PHASE_ACTIVE, WR_STROBE, SPI_EN, SPI_MASTER} = '0;
    {SPI_SCK_OUT, SPI_MASTER_OUT, SPI_SLAVE_OUT, CNT8_MATCH_EN, CNT8_MATCH_OUT} = '0;
    {PA_DIR_BIT, PA_OUT_BIT, PB_DIR_BIT, PB_OUT_BIT, MEM_ADDR_LO, MEM_DOUT, pa_xe, pa_xv, pb_xe, pb_xv} = '0;
    CE = 1'b1;
    err_total = 0;
    tests_run = 0;
    cyc = 0;
    repeat (8) tick();
    RSTN = 1'b1;
    repeat (3) tick();
    // ****
    // register path, comparator pins kept as inputs without pull-up
    // ****
    PA_DIR_BIT = 8'h0F;
    PA_OUT_BIT = 8'h3C;
    PB_DIR_BIT = 8'hF3;
    PB_OUT_BIT = 8'hF3;
    chk();
    GLOBAL_PULLUP_OFF = 1'b1;
    chk();
    GLOBAL_PULLUP_OFF = 1'b0;
    // ****
    // memory cycle: address, write, then idle with the far side driving data
    // ****
    EXT_MEM_ENABLE = 1'b1;
    ADDR_PHASE_ACTIVE = 1'b1;
    MEM_ADDR_LO = 8'hA5;
    chk();
    ADDR_PHASE_ACTIVE = 1'b0;
    WR_STROBE = 1'b1;
    MEM_DOUT = 8'h3C;
    chk();
    WR_STROBE = 1'b0;
    PA_OUT_BIT = 8'hF0;
    pa_xe = 8'hFF;
    pa_xv = 8'h5A;
    chk();
    tick();
    `CK("mem_din", MEM_DIN, 8'h5A)
    EXT_MEM_ENABLE = 1'b0;
    // ****
    // serial slave and master, with and without global pull-up disable
    // ****
    for (int k = 0; k < 4; k++) begin
      SPI_EN = 1'b1;
      SPI_MASTER = k[0];
      GLOBAL_PULLUP_OFF = k[1];
      SPI_SCK_OUT = !k[0];
      SPI_MASTER_OUT = 1'b1;
      SPI_SLAVE_OUT = 1'b1;
      chk();
    end
    // ****
    // select driven low by the far side, counter inputs and match output
    // ****
    SPI_MASTER = 1'b0;
    GLOBAL_PULLUP_OFF = 1'b0;
    PB_DIR_BIT = 8'h01;
    CNT8_MATCH_EN = 1'b1;
    CNT8_MATCH_OUT = 1'b1;
    pb_xe = 8'h12;
    pb_xv = 8'h02;
    chk();
    tick();
    `CK("slave_active", SPI_SLAVE_ACTIVE, 1'b1)
    `CK("select_n", SPI_SELECT_N, 1'b0)
    `CK("cnt16_in", CNT16_EXT_COUNT_IN, 1'b1)
    `CK("cnt8_in", CNT8_EXT_COUNT_IN, 1'b1)
    `CK("sck_in", SPI_SCK_IN, 1'b1)
    `CK("mst_in", SPI_MASTER_IN, 1'b1)
    `CK("slv_in", SPI_SLAVE_IN, 1'b1)
    `CK("pb_pins", PB_PIN_STATE & 8'hF3, 8'hE3)
    `CK("pa_pins", PA_PIN_STATE, 8'h50)
    pb_xv = 8'h12;
    tick();
    tick();
    `CK("slave_idle", SPI_SLAVE_ACTIVE, 1'b0)
    // ****
    // clock enable low holds the pad controls
    // ****
    CE = 1'b0;
    PA_OUT_BIT = 8'h0F;
    tick();
    `CK("ce_hold", PA_PAD_OUT, 8'hF0)
    CE = 1'b1;
    chk();
    // ****
    // reset in mid-run
    // ****
    RSTN = 1'b0;
    #1;
    `CK("oe_reset", PA_PAD_OE, 8'h00)
    `CK("select_reset", SPI_SELECT_N, 1'b1)
    tick();
    RSTN = 1'b1;
    repeat (3) tick();
    chk();
    stop_test();
  end
endmodule
